/* File: serial_port_map.vh */
// Register map, field positions, reset values and timing for the serial port.
// Included by the port design file; holds definitions only.
`ifndef SERIAL_PORT_MAP_VH
`define SERIAL_PORT_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_LINE_CFG 5'h00
`define OFS_COMMAND 5'h04
`define OFS_TX_DATA 5'h08
`define OFS_RX_DATA 5'h0c
`define OFS_STATUS 5'h10

// ----------------------------------------
// Line configuration fields
// ----------------------------------------
`define CFG_RATE_LSB 0
`define CFG_PAR_LSB 4
`define CFG_LEN_LSB 6
`define CFG_STOP_LSB 8
`define CFG_HALF_BIT 10
`define CFG_RESET 11'h0ce

// ----------------------------------------
// Command codes
// ----------------------------------------
`define CMD_HALT_TX 4'h1
`define CMD_RESUME_TX 4'h2
`define CMD_DISCONNECT 4'h3
`define CMD_START_RX 4'h4
`define CMD_SEND_THEN_LISTEN 4'h5

// ----------------------------------------
// Parity and stop encodings
// ----------------------------------------
`define PAR_NONE 2'h0
`define PAR_ODD 2'h1
`define PAR_EVEN 2'h2
`define STOP_ONE 2'h0
`define STOP_ONE_HALF 2'h1
`define STOP_TWO 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_HZ 20000000
`define DISC_MS 4000

`endif

/* File: serial_port.v */
// Asynchronous serial port: line transmitter, receiver, transmit FIFO and
// an Avalon-MM register slave. Assumes one 20 MHz clock mclk, rst async high,
// rxd from a modem pin (synchronised here).
//
// Implementation choices: the Avalon-MM register port and the address map.
`timescale 1ns/10ps
`include "serial_port_map.vh"

// ----------------------------------------
// Transmit FIFO
// ----------------------------------------
module tx_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 4,
  parameter AW = 2
) (
  input wire mclk,
  input wire rst,
  input wire flush,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam [AW:0] FULL_CNT = DEPTH;
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_reg;
  reg [AW-1:0] rd_reg;
  reg [AW:0] cnt_reg;
  wire push;
  wire pop;

  assign in_ready = (cnt_reg != FULL_CNT);
  assign out_valid = (cnt_reg != {(AW+1){1'b0}});
  assign out_data = mem[rd_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always @(posedge mclk)
  begin
    if (push)
      mem[wr_reg] <= in_data;
  end

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end
    else if (flush)
    begin
      wr_reg <= {AW{1'b0}};
      rd_reg <= {AW{1'b0}};
      cnt_reg <= {(AW+1){1'b0}};
    end
    else
    begin
      if (push)
        wr_reg <= wr_reg + {{(AW-1){1'b0}}, 1'b1};
      if (pop)
        rd_reg <= rd_reg + {{(AW-1){1'b0}}, 1'b1};
      if (push && !pop)
        cnt_reg <= cnt_reg + {{AW{1'b0}}, 1'b1};
      else if (pop && !push)
        cnt_reg <= cnt_reg - {{AW{1'b0}}, 1'b1};
    end
  end
endmodule // tx_fifo

// ----------------------------------------
// Serial port top
// ----------------------------------------
module serial_port #(
  parameter CLK_HZ = `CLK_HZ,
  parameter DISC_CYCLES = `DISC_MS * (`CLK_HZ / 1000)
) (
  input wire mclk,
  input wire rst,
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  output reg [31:0] readdata,
  output wire waitrequest,
  output reg txd,
  input wire rxd,
  output reg terminal_ready
);
  localparam S_IDLE = 5'h01;
  localparam S_START = 5'h02;
  localparam S_DATA = 5'h04;
  localparam S_PAR = 5'h08;
  localparam S_STOP = 5'h10;

  // ----------------------------------------
  // Bit-rate divisor per rate select
  // ----------------------------------------
  function [19:0] rate_div;
    input [3:0] sel;
    integer r10;
    reg [31:0] full;
    begin
      case (sel)
        4'h0: r10 = 500;
        4'h1: r10 = 750;
        4'h2: r10 = 1000;
        4'h3: r10 = 1100;
        4'h4: r10 = 1345;
        4'h5: r10 = 1500;
        4'h6: r10 = 2000;
        4'h7: r10 = 3000;
        4'h8: r10 = 6000;
        4'h9: r10 = 12000;
        4'ha: r10 = 24000;
        4'hb: r10 = 48000;
        default: r10 = 96000;
      endcase
      full = ((CLK_HZ * 10) + (r10 / 2)) / r10;
      rate_div = full[19:0];
    end
  endfunction

  reg [10:0] cfg_reg;
  reg halted_reg;
  reg listen_reg;
  reg stl_pend_reg;
  reg [31:0] disc_cnt_reg;
  reg rd_done_reg;
  reg [7:0] rx_buf_reg;
  reg rx_full_reg;
  reg par_err_reg;
  reg frame_err_reg;
  reg rxd_m_reg;
  reg rxd_s_reg;

  wire [19:0] div;
  wire [1:0] par_mode;
  wire [1:0] len;
  wire [1:0] stop_mode;
  wire half_dup;
  wire [7:0] mask;
  wire wr_cfg;
  wire wr_cmd;
  wire wr_tx;
  wire rd_rx;
  wire [3:0] cmd;
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire fifo_flush;
  wire tx_take;
  wire rx_clear;
  wire rx_done;
  wire tx_busy;

  assign div = rate_div(cfg_reg[`CFG_RATE_LSB+3:`CFG_RATE_LSB]);
  assign par_mode = cfg_reg[`CFG_PAR_LSB+1:`CFG_PAR_LSB];
  assign len = cfg_reg[`CFG_LEN_LSB+1:`CFG_LEN_LSB];
  assign stop_mode = cfg_reg[`CFG_STOP_LSB+1:`CFG_STOP_LSB];
  assign half_dup = cfg_reg[`CFG_HALF_BIT];
  assign mask = 8'hff >> (2'h3 - len);
  assign cmd = writedata[3:0];
  assign wr_cfg = write && (address == `OFS_LINE_CFG);
  assign wr_cmd = write && (address == `OFS_COMMAND);
  assign wr_tx = write && (address == `OFS_TX_DATA) && fifo_in_ready;
  assign rd_rx = read && !rd_done_reg && (address == `OFS_RX_DATA);
  assign waitrequest = (write && (address == `OFS_TX_DATA) && !fifo_in_ready) ||
    (read && !rd_done_reg);
  assign fifo_flush = wr_cmd && (cmd == `CMD_START_RX) && half_dup;
  assign rx_clear = (wr_tx || (wr_cmd && (cmd == `CMD_START_RX))) && half_dup;

  // ----------------------------------------
  // Transmit FIFO instance
  // ----------------------------------------
  tx_fifo #(
    .WIDTH(8),
    .DEPTH(4),
    .AW(2)
  ) u_fifo (
    .mclk(mclk),
    .rst(rst),
    .flush(fifo_flush),
    .in_valid(wr_tx),
    .in_ready(fifo_in_ready),
    .in_data({1'b0, writedata[6:0]}),
    .out_valid(fifo_out_valid),
    .out_ready(tx_take),
    .out_data(fifo_out_data)
  );

  // ----------------------------------------
  // Register bus and control
  // ----------------------------------------
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cfg_reg <= `CFG_RESET;
      halted_reg <= 1'b0;
      listen_reg <= 1'b0;
      stl_pend_reg <= 1'b0;
      disc_cnt_reg <= 32'h0;
      terminal_ready <= 1'b0;
      rd_done_reg <= 1'b0;
      readdata <= 32'h0;
    end
    else
    begin
      rd_done_reg <= read && !rd_done_reg;
      if (read && !rd_done_reg)
      begin
        case (address)
          `OFS_LINE_CFG: readdata <= {21'h0, cfg_reg};
          `OFS_RX_DATA: readdata <= {24'h0, rx_buf_reg};
          `OFS_STATUS: readdata <= {22'h0, frame_err_reg, par_err_reg, rx_full_reg,
            terminal_ready, stl_pend_reg, listen_reg, halted_reg,
            !fifo_in_ready, !fifo_out_valid, tx_busy};
          default: readdata <= 32'h0;
        endcase
      end
      terminal_ready <= (disc_cnt_reg == 32'h0);
      if (disc_cnt_reg != 32'h0)
        disc_cnt_reg <= disc_cnt_reg - 32'h1;
      if (wr_cfg)
        cfg_reg <= writedata[10:0];
      if (wr_tx)
      begin
        halted_reg <= 1'b0;
        if (half_dup)
          listen_reg <= 1'b0;
      end
      if (stl_pend_reg && !fifo_out_valid && !tx_busy)
      begin
        stl_pend_reg <= 1'b0;
        listen_reg <= 1'b1;
      end
      if (wr_cmd)
      begin
        case (cmd)
          `CMD_HALT_TX: halted_reg <= 1'b1;
          `CMD_RESUME_TX: halted_reg <= 1'b0;
          `CMD_DISCONNECT: disc_cnt_reg <= DISC_CYCLES;
          `CMD_START_RX: listen_reg <= 1'b1;
          `CMD_SEND_THEN_LISTEN:
          begin
            if (half_dup)
            begin
              stl_pend_reg <= 1'b1;
              listen_reg <= 1'b0;
              halted_reg <= 1'b0;
            end
          end
          default: halted_reg <= halted_reg;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  reg [4:0] tx_st_reg;
  reg [19:0] tx_tmr_reg;
  reg [7:0] tx_sh_reg;
  reg [2:0] tx_cnt_reg;
  reg tx_par_reg;
  wire tx_tick;
  wire [19:0] stop_len;

  assign tx_tick = (tx_tmr_reg == 20'h0);
  assign tx_busy = !tx_st_reg[0];
  assign tx_take = tx_st_reg[0] && fifo_out_valid && !halted_reg &&
    !(half_dup && listen_reg);
  assign stop_len = (stop_mode == `STOP_ONE_HALF) ? (div + (div >> 1)) :
    (stop_mode == `STOP_TWO) ? (div << 1) : div;

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      tx_st_reg <= S_IDLE;
      tx_tmr_reg <= 20'h0;
      tx_sh_reg <= 8'h0;
      tx_cnt_reg <= 3'h0;
      tx_par_reg <= 1'b0;
      txd <= 1'b1;
    end
    else
    begin
      if (!tx_tick)
        tx_tmr_reg <= tx_tmr_reg - 20'h1;
      case (tx_st_reg)
        S_IDLE:
        begin
          txd <= 1'b1;
          if (tx_take)
          begin
            tx_sh_reg <= fifo_out_data & mask;
            tx_par_reg <= (^(fifo_out_data & mask)) ^ (par_mode == `PAR_ODD);
            tx_cnt_reg <= {1'b0, len} + 3'h4;
            tx_tmr_reg <= div - 20'h1;
            txd <= 1'b0;
            tx_st_reg <= S_START;
          end
        end
        S_START:
        begin
          if (tx_tick)
          begin
            txd <= tx_sh_reg[0];
            tx_sh_reg <= tx_sh_reg >> 1;
            tx_tmr_reg <= div - 20'h1;
            tx_st_reg <= S_DATA;
          end
        end
        S_DATA:
        begin
          if (tx_tick)
          begin
            tx_tmr_reg <= div - 20'h1;
            if (tx_cnt_reg != 3'h0)
            begin
              txd <= tx_sh_reg[0];
              tx_sh_reg <= tx_sh_reg >> 1;
              tx_cnt_reg <= tx_cnt_reg - 3'h1;
            end
            else if (par_mode != `PAR_NONE)
            begin
              txd <= tx_par_reg;
              tx_st_reg <= S_PAR;
            end
            else
            begin
              txd <= 1'b1;
              tx_tmr_reg <= stop_len - 20'h1;
              tx_st_reg <= S_STOP;
            end
          end
        end
        S_PAR:
        begin
          if (tx_tick)
          begin
            txd <= 1'b1;
            tx_tmr_reg <= stop_len - 20'h1;
            tx_st_reg <= S_STOP;
          end
        end
        S_STOP:
        begin
          if (tx_tick)
            tx_st_reg <= S_IDLE;
        end
        default: tx_st_reg <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  reg [4:0] rx_st_reg;
  reg [19:0] rx_tmr_reg;
  reg [7:0] rx_sh_reg;
  reg [2:0] rx_cnt_reg;
  reg rx_pbit_reg;
  wire rx_tick;
  wire [7:0] rx_char;

  assign rx_tick = (rx_tmr_reg == 20'h0);
  assign rx_char = rx_sh_reg >> (2'h3 - len);
  assign rx_done = rx_st_reg[4] && rx_tick;

  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rxd_m_reg <= 1'b1;
      rxd_s_reg <= 1'b1;
      rx_st_reg <= S_IDLE;
      rx_tmr_reg <= 20'h0;
      rx_sh_reg <= 8'h0;
      rx_cnt_reg <= 3'h0;
      rx_pbit_reg <= 1'b0;
      rx_buf_reg <= 8'h0;
      rx_full_reg <= 1'b0;
      par_err_reg <= 1'b0;
      frame_err_reg <= 1'b0;
    end
    else
    begin
      rxd_m_reg <= rxd;
      rxd_s_reg <= rxd_m_reg;
      if (!rx_tick)
        rx_tmr_reg <= rx_tmr_reg - 20'h1;
      case (rx_st_reg)
        S_IDLE:
        begin
          if (listen_reg && !rxd_s_reg && !(half_dup && tx_busy))
          begin
            rx_tmr_reg <= (div >> 1) - 20'h1;
            rx_st_reg <= S_START;
          end
        end
        S_START:
        begin
          if (rx_tick)
          begin
            rx_tmr_reg <= div - 20'h1;
            rx_cnt_reg <= {1'b0, len} + 3'h4;
            rx_st_reg <= rxd_s_reg ? S_IDLE : S_DATA;
          end
        end
        S_DATA:
        begin
          if (rx_tick)
          begin
            rx_tmr_reg <= div - 20'h1;
            rx_sh_reg <= {rxd_s_reg, rx_sh_reg[7:1]};
            rx_cnt_reg <= rx_cnt_reg - 3'h1;
            if (rx_cnt_reg == 3'h0)
              rx_st_reg <= (par_mode != `PAR_NONE) ? S_PAR : S_STOP;
          end
        end
        S_PAR:
        begin
          if (rx_tick)
          begin
            rx_tmr_reg <= div - 20'h1;
            rx_pbit_reg <= rxd_s_reg;
            rx_st_reg <= S_STOP;
          end
        end
        S_STOP:
        begin
          if (rx_tick)
            rx_st_reg <= S_IDLE;
        end
        default: rx_st_reg <= S_IDLE;
      endcase
      if (rd_rx)
        rx_full_reg <= 1'b0;
      if (rx_clear)
        rx_full_reg <= 1'b0;
      if (rd_rx && (address == `OFS_RX_DATA))
      begin
        par_err_reg <= 1'b0;
        frame_err_reg <= 1'b0;
      end
      if (rx_done)
      begin
        rx_buf_reg <= rx_char;
        rx_full_reg <= 1'b1;
        frame_err_reg <= !rxd_s_reg;
        par_err_reg <= (par_mode != `PAR_NONE) &&
          (((^rx_char) ^ rx_pbit_reg) != (par_mode == `PAR_ODD));
      end
    end
  end
endmodule // serial_port

/* File: serial_port_asserts.sv */
// Concurrent checks on the serial port's bus and line pins.
// Assumes binding to serial_port; sees only its ports.
`timescale 1ns/10ps
`include "serial_port_map.vh"
module serial_port_asserts #(
  parameter CLK_HZ = 20000000,
  parameter DISC_CYCLES = 100
) (
  input wire mclk,
  input wire rst,
  input wire [4:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [31:0] readdata,
  input wire waitrequest,
  input wire txd,
  input wire rxd,
  input wire terminal_ready
);
  reg [10:0] cfg_reg;
  integer low_reg;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Shadow of line config, low-time counter
  // ----------------------------------------
  always @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cfg_reg <= `CFG_RESET;
      low_reg <= 0;
    end
    else
    begin
      if (write && !waitrequest && address == `OFS_LINE_CFG)
        cfg_reg <= writedata[10:0];
      low_reg <= terminal_ready ? 0 : low_reg + 1;
    end
  end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  sequence s_read_start;
    $rose(read);
  endsequence
  sequence s_read_answer;
    waitrequest ##1 !waitrequest;
  endsequence
  a_read_wait: assert property (s_read_start |-> s_read_answer)
    else $error("read answer timing wrong");
  a_write_nowait: assert property (write && address != `OFS_TX_DATA |-> !waitrequest)
    else $error("write stalled");
  a_unmapped_zero: assert property (read && !waitrequest
    && (address[1:0] != 2'h0 || address > 5'h10) |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  a_cfg_readback: assert property (
    read && !waitrequest && address == `OFS_LINE_CFG |-> readdata == {21'h0, cfg_reg})
    else $error("line config readback wrong");
  a_readdata_stands: assert property (!read |=> $stable(readdata))
    else $error("readdata changed without read");
  a_disc_drop: assert property (write && !waitrequest && address == `OFS_COMMAND
    && writedata[3:0] == `CMD_DISCONNECT |-> ##[1:2] !terminal_ready)
    else $error("terminal ready not dropped");
  a_disc_length: assert property (low_reg <= DISC_CYCLES + 2)
    else $error("terminal ready low too long");
  a_start_hold: assert property ($fell(txd) |-> !txd [*3])
    else $error("start bit too short");
endmodule // serial_port_asserts

bind serial_port serial_port_asserts #(.CLK_HZ(CLK_HZ), .DISC_CYCLES(DISC_CYCLES)) u_chk (
  .mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .txd(txd), .rxd(rxd), .terminal_ready(terminal_ready));

/* File: modem_model.sv */
// Line-side modem: logs frames seen on txd, sends characters on rxd.
// Assumes bit time and frame length set by the bench while idle.
`timescale 1ns/10ps
module modem_model (
  input wire mclk,
  input wire txd,
  input wire [15:0] bit_cycles,
  input wire [3:0] frame_bits,
  output reg rxd,
  output reg [7:0] n_frames
);
  reg [11:0] frame_log [0:15];
  reg [11:0] shift_reg;
  integer i;
  initial
  begin
    rxd = 1'b1;
    n_frames = 8'h00;
  end
  // ----------------------------------------
  // Frame capture, mid-bit sampling
  // ----------------------------------------
  always
  begin
    @(negedge txd);
    repeat (bit_cycles / 2) @(posedge mclk);
    shift_reg = 12'h000;
    for (i = 0; i < frame_bits; i = i + 1)
    begin
      shift_reg[i] = txd;
      if (i < frame_bits - 1)
        repeat (bit_cycles) @(posedge mclk);
    end
    frame_log[n_frames[3:0]] = shift_reg;
    n_frames = n_frames + 8'h01;
  end
  // ----------------------------------------
  // Character send, 8 data bits with bit 7 forced to 0, no parity
  // ----------------------------------------
  task send_char(input [7:0] c);
    reg [9:0] f;
    integer k;
    begin
      f = {1'b1, 1'b0, c[6:0], 1'b0};
      for (k = 0; k < 10; k = k + 1)
      begin
        rxd <= f[k];
        repeat (bit_cycles) @(posedge mclk);
      end
    end
  endtask
endmodule // modem_model

/* File: tb.sv */
// Self-checking bench for the serial port over Avalon-MM.
// Assumes short bit times via CLK_HZ and a short disconnect.
`timescale 1ns/10ps
`include "serial_port_map.vh"
module tb;
  localparam integer DISC = 100;
  reg mclk, rst, read, write;
  reg [4:0] address;
  reg [31:0] writedata, q;
  reg [15:0] bit_cycles;
  reg [3:0] frame_bits;
  reg [10:0] cfg;
  wire [31:0] readdata;
  wire waitrequest, txd, rxd, terminal_ready;
  wire [7:0] n_frames;
  integer n_fail, num_checks, i, k;
  serial_port #(.CLK_HZ(96000), .DISC_CYCLES(DISC)) u_serial_port (
    .mclk(mclk), .rst(rst), .address(address), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .txd(txd), .rxd(rxd), .terminal_ready(terminal_ready));
  modem_model u_modem_model (.mclk(mclk), .txd(txd), .bit_cycles(bit_cycles),
    .frame_bits(frame_bits), .rxd(rxd), .n_frames(n_frames));
  always #25 mclk = ~mclk;
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task give_verdict;
    begin
      if (n_fail == 0 && num_checks > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp)
      begin
        n_fail = n_fail + 1;
        $display("Error at %0t: got %h expected %h", $time, seen, exp);
      end
    end
  endtask
  task fail_out;
    begin
      n_fail = n_fail + 1;
      $display("Error at %0t: wait timed out", $time);
      give_verdict;
    end
  endtask
  task bus(input rd, input [4:0] a, input [31:0] d);
    integer w;
    begin
      address <= a;
      writedata <= d;
      read <= rd;
      write <= !rd;
      w = 0;
      @(posedge mclk);
      while (waitrequest !== 1'b0 && w < 5000)
      begin
        @(posedge mclk);
        w = w + 1;
      end
      q = readdata;
      read <= 1'b0;
      write <= 1'b0;
      @(posedge mclk);
      if (w >= 5000)
        fail_out;
    end
  endtask
  task wait_frames(input [7:0] n);
    begin
      k = 0;
      while (n_frames < n && k < 30000)
      begin
        @(posedge mclk);
        k = k + 1;
      end
      if (k >= 30000)
        fail_out;
    end
  endtask
  function integer nbits(input [1:0] len, input [1:0] par, input [1:0] stp);
    nbits = 7 + len + (par != `PAR_NONE) + (stp == `STOP_TWO);
  endfunction
  function [31:0] exp_frame(input [7:0] c, input [1:0] len, input [1:0] par,
    input [1:0] stp);
    integer j;
    reg p;
    reg [11:0] f;
    begin
      f = 12'hffe;
      p = (par == `PAR_ODD);
      for (j = 0; j < len + 5; j = j + 1)
      begin
        f[j + 1] = c[j];
        p = p ^ c[j];
      end
      if (par != `PAR_NONE)
        f[len + 6] = p;
      exp_frame = {20'h0, f & ~(12'hfff << nbits(len, par, stp))};
    end
  endfunction
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    mclk = 0; rst = 1; read = 0; write = 0; address = 0; writedata = 0;
    bit_cycles = 10; frame_bits = 10; n_fail = 0; num_checks = 0;
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    @(posedge mclk);
    bus(1, `OFS_LINE_CFG, 0);
    check(q, 32'h0ce);
    bus(1, `OFS_STATUS, 0);
    check(q & 32'h3ff, 32'h042);
    bus(1, 5'h14, 0);
    check(q, 32'h0);
    for (i = 0; i < 6; i = i + 1)
    begin
      bus(0, `OFS_TX_DATA, 32'hc1 + i);
      if (i == 4)
      begin
        bus(1, `OFS_STATUS, 0);
        check(q & 32'h4, 32'h4);
      end
    end
    bus(0, `OFS_COMMAND, `CMD_HALT_TX);
    wait_frames(2);
    repeat (300) @(posedge mclk);
    check(n_frames, 2);
    bus(1, `OFS_STATUS, 0);
    check(q & 32'he, 32'hc);
    bus(0, `OFS_COMMAND, `CMD_RESUME_TX);
    bus(0, `OFS_COMMAND, `CMD_RESUME_TX);
    wait_frames(6);
    for (i = 0; i < 6; i = i + 1)
      check(u_modem_model.frame_log[i], exp_frame(8'h41 + i, 3, 0, 0));
    bus(0, `OFS_COMMAND, `CMD_HALT_TX);
    bus(0, `OFS_TX_DATA, 32'h7e);
    wait_frames(7);
    check(u_modem_model.frame_log[6], exp_frame(8'h7e, 3, 0, 0));
    for (i = 0; i < 3; i = i + 1)
    begin
      cfg = (i == 0) ? 11'h19c : (i == 1) ? 11'h22b : 11'h04c;
      bit_cycles <= (cfg[3:0] == 4'hb) ? 16'd20 : 16'd10;
      frame_bits <= nbits(cfg[7:6], cfg[5:4], cfg[9:8]);
      bus(0, `OFS_LINE_CFG, {21'h0, cfg});
      bus(1, `OFS_LINE_CFG, 0);
      check(q, {21'h0, cfg});
      bus(0, `OFS_TX_DATA, 32'h2d ^ i);
      wait_frames(8 + i);
      check(u_modem_model.frame_log[7 + i],
        exp_frame(8'h2d ^ i, cfg[7:6], cfg[5:4], cfg[9:8]));
    end
    bit_cycles <= 16'd10;
    frame_bits <= 4'd10;
    bus(0, `OFS_LINE_CFG, 32'h0ce);
    bus(0, `OFS_COMMAND, `CMD_START_RX);
    u_modem_model.send_char(8'h5a);
    bus(1, `OFS_RX_DATA, 0);
    check(q & 32'hff, 32'h5a);
    bus(0, `OFS_LINE_CFG, 32'h4ce);
    bus(0, `OFS_COMMAND, `CMD_START_RX);
    u_modem_model.send_char(8'h33);
    bus(1, `OFS_STATUS, 0);
    check(q & 32'h80, 32'h80);
    bus(0, `OFS_TX_DATA, 32'h21);
    bus(1, `OFS_STATUS, 0);
    check(q & 32'h80, 32'h0);
    bus(0, `OFS_COMMAND, `CMD_SEND_THEN_LISTEN);
    wait_frames(11);
    check(u_modem_model.frame_log[10], exp_frame(8'h21, 3, 0, 0));
    q = 0;
    for (k = 0; k < 50 && q[4] !== 1'b1; k = k + 1)
      bus(1, `OFS_STATUS, 0);
    check(q & 32'h10, 32'h10);
    u_modem_model.send_char(8'h44);
    bus(1, `OFS_RX_DATA, 0);
    check(q & 32'hff, 32'h44);
    bus(0, `OFS_COMMAND, `CMD_DISCONNECT);
    k = 0;
    while (terminal_ready !== 1'b0 && k < 10)
    begin
      @(posedge mclk);
      k = k + 1;
    end
    k = 0;
    while (terminal_ready !== 1'b1 && k < 1000)
    begin
      @(posedge mclk);
      k = k + 1;
    end
    check(k >= DISC - 4 && k <= DISC + 2, 1);
    give_verdict;
  end
endmodule // tb
